//--- hdl/nco_core.sv
// Oscillator core: accumulator, control registers, Avalon slave, interrupts
//
// How it works
// - Enable bit 7 runs or halts oscillator
// - Bit 5 reads live final output level
// - Polarity bit 4 inverts final output
// - Mode bit 0 set: pulse per overflow
// - Mode bit 0 clear: toggle per overflow
// - Bits 6 and 3:1 read zero
// - 20-bit accumulator adds increment, carry overflows
// - Pulse mode output active then returns
// - Width field sets pulse active periods
// - Source field selects oscillator input clock
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module nco_core
  import nco_pkg::*;
#(
  parameter int ACC_WIDTH = 20
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [nco_pkg::SRC_N-1:0] srcClk,
  input  wire logic [nco_pkg::ADDR_W-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  output logic                       ncoOut,
  output logic                       irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  nco_cfg_t               cfg_r,     cfg_nxt;
  logic [ACC_WIDTH-1:0]   inc_r,     inc_nxt;
  logic [ACC_WIDTH-1:0]   incBuf_r,  incBuf_nxt;
  logic [ACC_WIDTH-1:0]   acc_r,     acc_nxt;
  logic                   incPend_r, incPend_nxt;
  logic [IRQ_N-1:0]       stat_r,    stat_nxt;
  logic [IRQ_N-1:0]       mask_r,    mask_nxt;
  logic [31:0]            rdata_r,   rdata_nxt;
  logic                   ack_r,     ack_nxt;
  logic                   out_r,     out_nxt;
  logic                   irq_r,     irq_nxt;
  logic                   carry;
  logic                   rawOut;
  logic [3:0]             regIdx;
  logic                   access;
  logic                   wrStrobe;

  // ----------------------------------------
  // Source clock synchronisers and edge detect
  // ----------------------------------------
  logic [SRC_N-1:0] srcMeta_r, srcSync_r, srcLast_r;
  logic             srcSel,    srcSelLast;
  logic             tick;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      srcMeta_r <= '0;
      srcSync_r <= '0;
      srcLast_r <= '0;
    end else begin
      srcMeta_r <= srcClk;
      srcSync_r <= srcMeta_r;
      srcLast_r <= srcSync_r;
    end
  end

  // Reserved codes select nothing, so the core never ticks
  always_comb begin
    srcSel     = 1'b0;
    srcSelLast = 1'b0;
    if (cfg_r.clockSourceSel < 3'(SRC_N)) begin
      srcSel     = srcSync_r[cfg_r.clockSourceSel];
      srcSelLast = srcLast_r[cfg_r.clockSourceSel];
    end
  end

  assign tick = cfg_r.enable && srcSel && !srcSelLast;

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  logic [ACC_WIDTH:0] sum;
  assign sum   = {1'b0, acc_r} + {1'b0, incBuf_r};
  assign carry = sum[ACC_WIDTH];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign regIdx = address[ADDR_W-1:2];
  assign access   = (read || write) && !ack_r;
  // Write lands at the edge where the master sees waitrequest low
  assign wrStrobe = write && ack_r;

  always_comb begin
    cfg_nxt     = cfg_r;
    inc_nxt     = inc_r;
    incBuf_nxt  = incBuf_r;
    acc_nxt     = acc_r;
    incPend_nxt = incPend_r;
    stat_nxt    = stat_r;
    mask_nxt    = mask_r;
    rdata_nxt   = rdata_r;
    ack_nxt     = access;
    if (tick) begin
      acc_nxt = sum[ACC_WIDTH-1:0];
      if (incPend_r) begin
        incBuf_nxt  = inc_r;
        incPend_nxt = 1'b0;
      end
    end
    if (!cfg_r.enable) begin
      incBuf_nxt  = inc_r;
      incPend_nxt = 1'b0;
    end
    if (wrStrobe) begin
      unique case (regIdx)
        OFS_CONTROL: begin
          // Read-only and unused bits are masked off
          cfg_nxt.enable    = writedata[BIT_ENABLE];
          cfg_nxt.invert    = writedata[BIT_INVERT];
          cfg_nxt.pulseMode = writedata[BIT_PULSEMODE];
        end
        OFS_CLKCFG: begin
          cfg_nxt.pulseWidthSel  = writedata[PWS_LSB +: 3];
          cfg_nxt.clockSourceSel = writedata[CKS_LSB +: 3];
        end
        OFS_INC: begin
          inc_nxt     = writedata[ACC_WIDTH-1:0];
          incPend_nxt = 1'b1;
        end
        OFS_ACC: acc_nxt = writedata[ACC_WIDTH-1:0];
        OFS_IRQSTAT: stat_nxt = stat_r & ~writedata[IRQ_N-1:0];
        OFS_IRQMASK: mask_nxt = writedata[IRQ_N-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (tick && carry) stat_nxt[IRQ_CARRY] = 1'b1;
    if (out_nxt != out_r) stat_nxt[IRQ_EDGE] = 1'b1;
    if (access && read) begin
      rdata_nxt = 32'h0000_0000;
      unique case (regIdx)
        OFS_CONTROL: begin
          rdata_nxt[BIT_ENABLE]    = cfg_r.enable;
          rdata_nxt[BIT_OUTSTATE]  = out_r;
          rdata_nxt[BIT_INVERT]    = cfg_r.invert;
          rdata_nxt[BIT_PULSEMODE] = cfg_r.pulseMode;
        end
        OFS_CLKCFG: begin
          rdata_nxt[PWS_LSB +: 3] = cfg_r.pulseWidthSel;
          rdata_nxt[CKS_LSB +: 3] = cfg_r.clockSourceSel;
        end
        OFS_INC:     rdata_nxt[ACC_WIDTH-1:0] = inc_r;
        OFS_ACC:     rdata_nxt[ACC_WIDTH-1:0] = acc_r;
        OFS_IRQSTAT: rdata_nxt[IRQ_N-1:0]     = stat_r;
        OFS_IRQMASK: rdata_nxt[IRQ_N-1:0]     = mask_r;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  nco_pulse_gen u_pulse (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .tick          (tick),
    .carry         (carry),
    .enable        (cfg_r.enable),
    .pulseMode     (cfg_r.pulseMode),
    .pulseWidthSel (cfg_r.pulseWidthSel),
    .rawOut        (rawOut)
  );

  always_comb begin
    out_nxt = rawOut ^ cfg_r.invert;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_r     <= nco_cfg_t'(9'h000);
      inc_r     <= '0;
      incBuf_r  <= '0;
      acc_r     <= '0;
      incPend_r <= 1'b0;
      stat_r    <= '0;
      mask_r    <= '0;
      rdata_r   <= 32'h0000_0000;
      ack_r     <= 1'b0;
      out_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      inc_r     <= inc_nxt;
      incBuf_r  <= incBuf_nxt;
      acc_r     <= acc_nxt;
      incPend_r <= incPend_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      rdata_r   <= rdata_nxt;
      ack_r     <= ack_nxt;
      out_r     <= out_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign readdata    = rdata_r;
  assign waitrequest = !ack_r;
  assign ncoOut      = out_r;
  assign irq         = irq_r;

  // ----------------------------------------
  // Pulse width monitor for the checks
  // ----------------------------------------
  // Saturates so a long idle gap cannot wrap back into a pulse
  logic [8:0] ticksSeen_r, ticksSeen_nxt;
  logic       pulseActive;

  always_comb begin
    ticksSeen_nxt = ticksSeen_r;
    if (!cfg_r.enable || !cfg_r.pulseMode) begin
      ticksSeen_nxt = 9'h000;
    end else if (tick && carry) begin
      ticksSeen_nxt = 9'h001;
    end else if (tick && ticksSeen_r != 9'h000 && ticksSeen_r != 9'h1FF) begin
      ticksSeen_nxt = ticksSeen_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ticksSeen_r <= 9'h000;
    end else begin
      ticksSeen_r <= ticksSeen_nxt;
    end
  end

  assign pulseActive = (ticksSeen_r != 9'h000)
                       && (ticksSeen_r <= (9'h001 << cfg_r.pulseWidthSel));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_disabled_halts: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !cfg_r.enable |-> !tick)
    else $error("tick while disabled");

  a_status_mirror: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    read && !ack_r && regIdx == OFS_CONTROL |=> readdata[BIT_OUTSTATE] == $past(out_r))
    else $error("status bit does not show output");

  a_invert_follows: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> out_r == ($past(rawOut) ^ $past(cfg_r.invert)))
    else $error("output polarity wrong");

  // Disabled core parks its output at the inactive level
  a_invert_idle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !cfg_r.enable |=> ##1 out_r == $past(cfg_r.invert))
    else $error("idle level ignores polarity");

  a_pulse_starts: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tick && carry && cfg_r.pulseMode |=> ##1 out_r != cfg_r.invert)
    else $error("pulse not raised on overflow");

  a_toggle_flips: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tick && carry && !cfg_r.pulseMode && cfg_r.enable && $stable(cfg_r.invert)
    |=> rawOut != $past(rawOut))
    else $error("toggle missed");

  a_unused_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $past(read && !ack_r && regIdx == OFS_CONTROL)
    |-> readdata[6] == 1'b0 && readdata[3:1] == 3'b000)
    else $error("unused bits not zero");

  a_readonly_kept: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    wrStrobe && regIdx == OFS_CONTROL |=> out_r == ($past(rawOut) ^ $past(cfg_r.invert)))
    else $error("write disturbed output");

  // Only the writable positions reach the control fields
  a_control_lands: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    wrStrobe && regIdx == OFS_CONTROL |=> cfg_r.enable == $past(writedata[BIT_ENABLE])
    && cfg_r.invert == $past(writedata[BIT_INVERT])
    && cfg_r.pulseMode == $past(writedata[BIT_PULSEMODE]))
    else $error("control write misplaced");

  a_acc_adds: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tick && !(wrStrobe && regIdx == OFS_ACC)
    |=> acc_r == ACC_WIDTH'($past(acc_r) + $past(incBuf_r)))
    else $error("accumulator did not add");

  a_carry_flags: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tick && carry |=> stat_r[IRQ_CARRY])
    else $error("carry not flagged");

  a_incbuf_loads: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !cfg_r.enable |=> incBuf_r == $past(inc_r))
    else $error("increment not loaded while disabled");

  a_src_reserved: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cfg_r.clockSourceSel >= 3'(SRC_N) |-> !tick)
    else $error("tick from reserved source");

  // Mid-pulse width changes are not modelled here
  a_width_counts: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    cfg_r.enable && cfg_r.pulseMode && ticksSeen_r != 9'h000 |-> rawOut == pulseActive)
    else $error("pulse width wrong");

  a_irq_level: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    irq == |(stat_r & mask_r))
    else $error("irq mismatch");

  a_bus_answers: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no answer in one cycle");

  c_toggle_mode:  cover property (@(posedge ref_clk) tick && carry && !cfg_r.pulseMode);
  c_pulse_mode:   cover property (@(posedge ref_clk) tick && carry && cfg_r.pulseMode);
  c_irq_raise:    cover property (@(posedge ref_clk) $rose(irq));
  c_wide_pulse:   cover property (@(posedge ref_clk) ticksSeen_r == 9'h002 && rawOut);
  c_reserved_src: cover property (@(posedge ref_clk)
    cfg_r.enable && cfg_r.clockSourceSel >= 3'(SRC_N));

endmodule : nco_core

//--- hdl/nco_pkg.sv
// Package: register map, field layout and constants of the oscillator block
package nco_pkg;

  // ----------------------------------------
  // Register word indices (byte address is index times 4)
  // ----------------------------------------
  localparam logic [3:0] OFS_CONTROL   = 4'h0;
  localparam logic [3:0] OFS_CLKCFG    = 4'h1;
  localparam logic [3:0] OFS_INC       = 4'h2;
  localparam logic [3:0] OFS_ACC       = 4'h3;
  localparam logic [3:0] OFS_IRQSTAT   = 4'h4;
  localparam logic [3:0] OFS_IRQMASK   = 4'h5;
  localparam int         ADDR_W        = 6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_OUTSTATE  = 5;
  localparam int BIT_INVERT    = 4;
  localparam int BIT_PULSEMODE = 0;
  localparam int PWS_LSB       = 5;
  localparam int CKS_LSB       = 0;
  localparam int IRQ_CARRY     = 0;
  localparam int IRQ_EDGE      = 1;

  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  CLKCFG_RST  = 8'h00;
  localparam logic [7:0]  CONTROL_WMASK = 8'h91;
  localparam logic [7:0]  CLKCFG_WMASK  = 8'hE7;
  localparam int          ACC_W       = 20;
  localparam int          SRC_N       = 6;
  localparam int          IRQ_N       = 2;

  typedef struct packed {
    logic       enable;
    logic       invert;
    logic       pulseMode;
    logic [2:0] pulseWidthSel;
    logic [2:0] clockSourceSel;
  } nco_cfg_t;

endpackage : nco_pkg

//--- hdl/nco_pulse_gen.sv
// Pulse shaper: toggle or stretched-pulse output from carry events
`timescale 1ns/1ps
module nco_pulse_gen
  import nco_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic tick,
  input  wire logic carry,
  input  wire logic enable,
  input  wire logic pulseMode,
  input  wire logic [2:0] pulseWidthSel,
  output logic      rawOut
);

  logic       rawOut_r,  rawOut_nxt;
  logic [7:0] width_r,   width_nxt;

  assign rawOut = rawOut_r;

  always_comb begin
    rawOut_nxt = rawOut_r;
    width_nxt  = width_r;
    if (!enable) begin
      rawOut_nxt = 1'b0;
      width_nxt  = 8'h00;
    end else if (tick) begin
      if (!pulseMode) begin
        if (carry) rawOut_nxt = ~rawOut_r;
        width_nxt = 8'h00;
      end else if (carry) begin
        rawOut_nxt = 1'b1;
        width_nxt  = 8'(8'h01 << pulseWidthSel) - 8'h01;
      end else if (width_r != 8'h00) begin
        width_nxt = width_r - 8'h01;
      end else begin
        rawOut_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rawOut_r <= 1'b0;
      width_r  <= 8'h00;
    end else begin
      rawOut_r <= rawOut_nxt;
      width_r  <= width_nxt;
    end
  end

  a_pulse_returns: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    enable && pulseMode && tick && !carry && width_r == 8'h00 |=> !rawOut_r)
    else $error("pulse did not return inactive");

endmodule : nco_pulse_gen

//--- tb/tb_nco_core.sv
// Testbench: register access, toggle and pulse output, interrupts
`timescale 1ns/1ps
module tb_nco_core;
  import nco_pkg::*;

  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic        ref_clk;
  logic        sys_rst;
  logic [5:0]  srcClk;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ncoOut;
  logic        irq;
  logic [31:0] rd;
  int          n_errors;
  int          samples_checked;

  nco_core #(.ACC_WIDTH(20)) i_nco_core (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .srcClk     (srcClk),
    .address    (address),
    .read       (read),
    .write      (write),
    .writedata  (writedata),
    .readdata   (readdata),
    .waitrequest(waitrequest),
    .ncoOut     (ncoOut),
    .irq        (irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Slave latency is one cycle, but no count is assumed
  task automatic waitAck();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      k++;
      if (k > 50) begin
        n_errors++;
        wrap_up();
      end
      @(posedge ref_clk);
    end
  endtask : waitAck

  // Extra edge after release keeps strobes from being driven twice at once
  task automatic busWrite(input logic [3:0] idx, input logic [31:0] d);
    address   <= {idx, 2'b00};
    writedata <= d;
    write     <= 1'b1;
    waitAck();
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : busWrite

  task automatic busRead(input logic [3:0] idx, output logic [31:0] d);
    address <= {idx, 2'b00};
    read    <= 1'b1;
    waitAck();
    d = readdata;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask : busRead

  // Source edges held 4 cycles each to clear the 2-FF synchroniser
  task automatic tickSrc(input int s, input int n);
    repeat (n) begin
      srcClk[s] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      srcClk[s] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask : tickSrc

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testReset();
    busRead(OFS_CONTROL, rd);
    check("control reset", 32'h0000_0000, rd);
    busRead(OFS_CLKCFG, rd);
    check("clkcfg reset", 32'h0000_0000, rd);
    busRead(4'h7, rd);
    check("unmapped read", 32'h0000_0000, rd);
    check("out reset", 32'h0000_0000, {31'h0, ncoOut});
    check("irq reset", 32'h0000_0000, {31'h0, irq});
    $display("test reset done");
  endtask : testReset

  task automatic testControl();
    busWrite(OFS_CONTROL, 32'h0000_006E);
    busRead(OFS_CONTROL, rd);
    check("ro bits", 32'h0000_0000, rd);
    check("out after ro write", 32'h0000_0000, {31'h0, ncoOut});
    busWrite(OFS_CONTROL, 32'h0000_0010);
    repeat (2) @(posedge ref_clk);
    check("inverted out", 32'h0000_0001, {31'h0, ncoOut});
    busRead(OFS_CONTROL, rd);
    check("live out bit", 32'h0000_0030, rd);
    busWrite(OFS_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check("plain out", 32'h0000_0000, {31'h0, ncoOut});
    $display("test control done");
  endtask : testControl

  task automatic testToggle();
    busWrite(OFS_IRQMASK, 32'h0000_0001);
    busWrite(OFS_INC, 32'h0008_0000);
    busWrite(OFS_CLKCFG, 32'h0000_0000);
    busWrite(OFS_CONTROL, 32'h0000_0080);
    tickSrc(0, 1);
    check("toggle tick1", 32'h0000_0000, {31'h0, ncoOut});
    busRead(OFS_ACC, rd);
    check("acc tick1", 32'h0008_0000, rd);
    tickSrc(0, 1);
    check("toggle tick2", 32'h0000_0001, {31'h0, ncoOut});
    check("irq on carry", 32'h0000_0001, {31'h0, irq});
    busRead(OFS_IRQSTAT, rd);
    check("irq status", 32'h0000_0003, rd);
    busWrite(OFS_IRQSTAT, 32'h0000_0001);
    busRead(OFS_IRQSTAT, rd);
    check("status cleared", 32'h0000_0002, rd);
    check("irq cleared", 32'h0000_0000, {31'h0, irq});
    tickSrc(1, 1);
    busRead(OFS_ACC, rd);
    check("other source", 32'h0000_0000, rd);
    busWrite(OFS_IRQMASK, 32'h0000_0000);
    tickSrc(0, 2);
    check("toggle tick4", 32'h0000_0000, {31'h0, ncoOut});
    check("irq masked", 32'h0000_0000, {31'h0, irq});
    $display("test toggle done");
  endtask : testToggle

  // Carry every fourth tick; width kept below the overflow period
  task automatic testPulse();
    for (int w = 0; w < 2; w++) begin
      busWrite(OFS_CONTROL, 32'h0000_0000);
      busWrite(OFS_ACC, 32'h0000_0000);
      busWrite(OFS_INC, 32'h0004_0000);
      busWrite(OFS_CLKCFG, 32'h0000_0002 | (32'(w) << 5));
      tickSrc(2, 2);
      busRead(OFS_ACC, rd);
      check("disabled acc", 32'h0000_0000, rd);
      busWrite(OFS_CONTROL, 32'h0000_0081);
      tickSrc(2, 3);
      check("pulse idle", 32'h0000_0000, {31'h0, ncoOut});
      tickSrc(2, 1);
      check("pulse start", 32'h0000_0001, {31'h0, ncoOut});
      if (w == 1) begin
        tickSrc(2, 1);
        check("pulse held", 32'h0000_0001, {31'h0, ncoOut});
      end
      tickSrc(2, 1);
      check("pulse end", 32'h0000_0000, {31'h0, ncoOut});
    end
    busWrite(OFS_CONTROL, 32'h0000_0000);
    busWrite(OFS_ACC, 32'h0000_0000);
    busWrite(OFS_CLKCFG, 32'h0000_0007);
    busWrite(OFS_CONTROL, 32'h0000_0080);
    tickSrc(0, 1);
    tickSrc(2, 1);
    busRead(OFS_ACC, rd);
    check("reserved source", 32'h0000_0000, rd);
    busWrite(OFS_CONTROL, 32'h0000_0000);
    $display("test pulse done");
  endtask : testPulse

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    n_errors        = 0;
    samples_checked = 0;
    sys_rst   = 1'b1;
    srcClk    = 6'h00;
    address   = 6'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    testReset();
    testControl();
    testToggle();
    testPulse();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end

endmodule : tb_nco_core
